// ---- logic/billboard_switchover_control.sv ----
// billboard switchover: apb registers, fail pin select, detach sequencing
// assumes a host-side usb function that obeys func_ctrl and reports events
// Function
// - low fail input with enable activates billboard
// - bits 5:1 select fail pin, default 01010
// - bit 0 enables feature, bits 7:6 zero
// - activation first forces function detach
// - reattach with billboard 1.1 identity
// - timer a starts on address set
// - identity only on failure, bmconfigured 00b
// - alternate mode string request starts timer b
// - timer expiry detaches, reattaches standard identity
// - timer counts are 10 ms units
// - timer a defaults 07d0h, 20 s
// - timer b also defaults to 20 s
// - timer a high, timer b bytes mapped
`timescale 1ns/10ps
module billboard_switchover_control #(
  parameter int unsigned TICK_CYCLES = billboard_pkg::TICK_CYCLES_DEF,
  parameter int unsigned DETACH_HOLD = billboard_pkg::DETACH_CYCLES
) (
  input  wire logic                                 pclk,
  input  wire logic                                 presetn,
  input  wire logic [billboard_pkg::APB_ADDR_W-1:0] paddr,
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [31:0]                          pwdata,
  input  wire logic [3:0]                           pstrb,
  output logic      [31:0]                          prdata,
  output logic                                      pready,
  output logic                                      pslverr,
  input  wire logic [billboard_pkg::NUM_FAIL_PINS-1:0] gpio_in,
  input  wire logic                                 addr_set,
  input  wire logic                                 alt_string_req,
  output billboard_pkg::func_ctrl_type              func_ctrl,
  output logic                                      alt_string_grant,
  output logic      [1:0]                           bm_configured
);
  import billboard_pkg::*;

  logic [7:0]               control_reg;
  logic [7:0]               ta_lo_reg;
  logic [7:0]               ta_hi_reg;
  logic [7:0]               tb_lo_reg;
  logic [7:0]               tb_hi_reg;
  mode_type                 state_reg;
  logic [HOLD_W-1:0]        hold_cnt_reg;
  logic [31:0]              tick_cnt_reg;
  logic                     tick_reg;
  logic                     armed_reg;
  logic [NUM_FAIL_PINS-1:0] gpio_sync;
  logic [4:0]               sel;
  logic                     fail_level;
  logic                     activate;
  logic                     hold_done;
  logic                     wr_en;
  logic                     mapped;
  logic [7:0]               rd_byte;
  logic                     ta_run;
  logic                     tb_run;
  logic                     ta_exp;
  logic                     tb_exp;
  logic                     leave_bb;
  status_type               status;

  pin_sync #(
    .WIDTH (NUM_FAIL_PINS)
  ) u_sync (
    .pclk         (pclk),
    .presetn      (presetn),
    .pin_in       (gpio_in),
    .pin_sync_out (gpio_sync)
  );

  // pin select; reserved and unused codes read as inactive high
  assign sel = control_reg[CTRL_SEL_MSB:CTRL_SEL_LSB];
  always_comb begin
    if (sel == SEL_RESERVED || sel > SEL_LAST) begin
      fail_level = 1'b1;
    end else begin
      fail_level = gpio_sync[sel];
    end
  end

  // re-arm only after the pin returns high, so a stuck-low pin
  // does not loop through billboard forever
  assign activate  = control_reg[CTRL_EN_BIT] && !fail_level && armed_reg;
  assign hold_done = hold_cnt_reg == HOLD_W'(DETACH_HOLD - 1);
  assign leave_bb  = state_reg == ST_BILLBOARD && (ta_exp || tb_exp);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_reg <= 1'b1;
    end else if (fail_level) begin
      armed_reg <= 1'b1;
    end else if (state_reg == ST_STANDARD && activate) begin
      armed_reg <= 1'b0;
    end
  end

  // free-running 10 ms prescaler: first tick after a start comes
  // up to one unit early, a deliberate trade for one shared counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
      tick_reg     <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_STANDARD;
    end else begin
      unique case (state_reg)
        ST_STANDARD: begin
          if (activate) state_reg <= ST_DETACH_TO_BB;
        end
        ST_DETACH_TO_BB: begin
          if (hold_done) state_reg <= ST_BILLBOARD;
        end
        ST_BILLBOARD: begin
          if (ta_exp || tb_exp) state_reg <= ST_DETACH_TO_STD;
        end
        ST_DETACH_TO_STD: begin
          if (hold_done) state_reg <= ST_STANDARD;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt_reg <= '0;
    end else if (state_reg == ST_DETACH_TO_BB || state_reg == ST_DETACH_TO_STD) begin
      hold_cnt_reg <= hold_done ? '0 : hold_cnt_reg + HOLD_W'(1);
    end else begin
      hold_cnt_reg <= '0;
    end
  end

  // connection and identity follow the next state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_ctrl <= '{connect: 1'b1, billboard_id: 1'b0};
    end else if (state_reg == ST_STANDARD && activate) begin
      func_ctrl.connect <= 1'b0;
    end else if (state_reg == ST_DETACH_TO_BB && hold_done) begin
      func_ctrl <= '{connect: 1'b1, billboard_id: 1'b1};
    end else if (leave_bb) begin
      func_ctrl.connect <= 1'b0;
    end else if (state_reg == ST_DETACH_TO_STD && hold_done) begin
      func_ctrl <= '{connect: 1'b1, billboard_id: 1'b0};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_string_grant <= 1'b0;
      bm_configured    <= BM_CFG_UNSPECIFIED;
    end else begin
      alt_string_grant <= state_reg == ST_BILLBOARD && alt_string_req;
      bm_configured    <= BM_CFG_UNSPECIFIED;
    end
  end

  detach_timer #(
    .WIDTH (TIMER_W)
  ) u_timer_a (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (state_reg == ST_BILLBOARD && addr_set),
    .stop    (state_reg != ST_BILLBOARD),
    .tick    (tick_reg),
    .load    ({ta_hi_reg, ta_lo_reg}),
    .running (ta_run),
    .expired (ta_exp),
    .count   ()
  );

  detach_timer #(
    .WIDTH (TIMER_W)
  ) u_timer_b (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (state_reg == ST_BILLBOARD && alt_string_req),
    .stop    (state_reg != ST_BILLBOARD),
    .tick    (tick_reg),
    .load    ({tb_hi_reg, tb_lo_reg}),
    .running (tb_run),
    .expired (tb_exp),
    .count   ()
  );

  // apb slave: one wait-free access, answer prepared in the setup cycle
  assign wr_en = psel && penable && pwrite && pready && pstrb[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg <= CONTROL_RESET;
      ta_lo_reg   <= TIMER_RESET_LO;
      ta_hi_reg   <= TIMER_RESET_HI;
      tb_lo_reg   <= TIMER_RESET_LO;
      tb_hi_reg   <= TIMER_RESET_HI;
    end else if (wr_en) begin
      if (paddr == reg_addr(IDX_CONTROL)) control_reg <= {2'b00, pwdata[5:0]};
      if (paddr == reg_addr(IDX_TA_LO))   ta_lo_reg   <= pwdata[7:0];
      if (paddr == reg_addr(IDX_TA_HI))   ta_hi_reg   <= pwdata[7:0];
      if (paddr == reg_addr(IDX_TB_LO))   tb_lo_reg   <= pwdata[7:0];
      if (paddr == reg_addr(IDX_TB_HI))   tb_hi_reg   <= pwdata[7:0];
    end
  end

  assign status = '{fail_level: fail_level, timer_b_run: tb_run, timer_a_run: ta_run,
                    connected: func_ctrl.connect, billboard_id: func_ctrl.billboard_id};

  always_comb begin
    mapped  = 1'b1;
    rd_byte = 8'h00;
    unique case (paddr)
      reg_addr(IDX_CONTROL): rd_byte = control_reg;
      reg_addr(IDX_TA_LO):   rd_byte = ta_lo_reg;
      reg_addr(IDX_TA_HI):   rd_byte = ta_hi_reg;
      reg_addr(IDX_TB_LO):   rd_byte = tb_lo_reg;
      reg_addr(IDX_TB_HI):   rd_byte = tb_hi_reg;
      reg_addr(IDX_STATUS):  rd_byte = 8'({status});
      default:               mapped  = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready  <= 1'b1;
      pslverr <= !mapped || (pwrite && paddr == reg_addr(IDX_STATUS));
      prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
  end

  property p_activate;
    @(posedge pclk) disable iff (!presetn)
    (state_reg == ST_STANDARD && activate)
      |=> (!func_ctrl.connect && state_reg == ST_DETACH_TO_BB);
  endproperty
  a_activate: assert property (p_activate) else $error("no detach on fail");

  property p_disabled;
    @(posedge pclk) disable iff (!presetn)
    (state_reg == ST_STANDARD && !control_reg[CTRL_EN_BIT]) |=> state_reg == ST_STANDARD;
  endproperty
  a_disabled: assert property (p_disabled) else $error("left standard while off");

  property p_reserved_sel;
    @(posedge pclk) disable iff (!presetn)
    (sel == SEL_RESERVED || sel > SEL_LAST) |-> fail_level;
  endproperty
  a_reserved_sel: assert property (p_reserved_sel) else $error("reserved pin code used");

  property p_ctrl_top_zero;
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == reg_addr(IDX_CONTROL)) |=> prdata[7:6] == 2'b00;
  endproperty
  a_ctrl_top_zero: assert property (p_ctrl_top_zero) else $error("control top bits set");

  property p_reattach_bb;
    @(posedge pclk) disable iff (!presetn)
    $rose(state_reg == ST_DETACH_TO_BB) |-> !func_ctrl.connect [*2];
  endproperty
  a_reattach_bb: assert property (p_reattach_bb) else $error("detach too short");

  property p_identity_cause;
    @(posedge pclk) disable iff (!presetn)
    $rose(func_ctrl.billboard_id) |-> func_ctrl.connect && $past(state_reg) == ST_DETACH_TO_BB;
  endproperty
  a_identity_cause: assert property (p_identity_cause) else $error("identity w/o fail");

  property p_timer_a_start;
    @(posedge pclk) disable iff (!presetn)
    (state_reg == ST_BILLBOARD && addr_set) |=> ##1 ta_run || ta_exp;
  endproperty
  a_timer_a_start: assert property (p_timer_a_start) else $error("timer a idle");

  property p_string;
    @(posedge pclk) disable iff (!presetn)
    (state_reg == ST_BILLBOARD && alt_string_req) |=> alt_string_grant ##1 (tb_run || tb_exp);
  endproperty
  a_string: assert property (p_string) else $error("string not served");

  property p_expire;
    @(posedge pclk) disable iff (!presetn)
    leave_bb |=> !func_ctrl.connect && state_reg == ST_DETACH_TO_STD;
  endproperty
  a_expire: assert property (p_expire) else $error("no detach on expiry");

  property p_return_std;
    @(posedge pclk) disable iff (!presetn)
    (state_reg == ST_DETACH_TO_STD && hold_done) |=> func_ctrl.connect && !func_ctrl.billboard_id;
  endproperty
  a_return_std: assert property (p_return_std) else $error("no standard reattach");

  c_activate: cover property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_STANDARD && activate);
  c_expire_a: cover property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_BILLBOARD && ta_exp);
  c_expire_b: cover property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_BILLBOARD && tb_exp);
endmodule : billboard_switchover_control

// ---- logic/billboard_pkg.sv ----
// constants, types and register map for the billboard switchover block
// assumes a 200 MHz core clock and an apb master with 32-bit data
package billboard_pkg;

  localparam int unsigned CLK_PERIOD_NS   = 5;
  localparam int unsigned TICK_TIME_MS    = 10;
  localparam int unsigned TICK_CYCLES_DEF = TICK_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned DETACH_TIME_US  = 10;
  localparam int unsigned DETACH_CYCLES   =
    (DETACH_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned APB_ADDR_W = 20;
  localparam int unsigned HOLD_W     = 16;
  localparam int unsigned TIMER_W    = 16;
  localparam int unsigned NUM_FAIL_PINS = 17;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_CONTROL = 16'h0004;
  localparam logic [15:0] IDX_TA_LO   = 16'h413c;
  localparam logic [15:0] IDX_TA_HI   = 16'h413d;
  localparam logic [15:0] IDX_TB_LO   = 16'h413e;
  localparam logic [15:0] IDX_TB_HI   = 16'h413f;
  localparam logic [15:0] IDX_STATUS  = 16'h4140;

  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned CTRL_SEL_LSB = 1;
  localparam int unsigned CTRL_SEL_MSB = 5;
  localparam logic [7:0]  CONTROL_RESET  = 8'h14;
  localparam logic [7:0]  TIMER_RESET_LO = 8'hd0;
  localparam logic [7:0]  TIMER_RESET_HI = 8'h07;
  localparam logic [4:0]  SEL_RESERVED   = 5'h09;
  localparam logic [4:0]  SEL_LAST       = 5'h10;
  localparam logic [1:0]  BM_CFG_UNSPECIFIED = 2'h0;

  typedef enum logic [1:0] {
    ST_STANDARD,
    ST_DETACH_TO_BB,
    ST_BILLBOARD,
    ST_DETACH_TO_STD
  } mode_type;

  typedef struct packed {
    logic connect;
    logic billboard_id;
  } func_ctrl_type;

  typedef struct packed {
    logic fail_level;
    logic timer_b_run;
    logic timer_a_run;
    logic connected;
    logic billboard_id;
  } status_type;

  function automatic logic [APB_ADDR_W-1:0] reg_addr(input logic [15:0] idx);
    reg_addr = APB_ADDR_W'({idx, 2'b00});
  endfunction : reg_addr

endpackage : billboard_pkg

// ---- logic/pin_sync.sv ----
// two-flop synchroniser for a vector of pin inputs
// assumes each bit is an independent slow level
`timescale 1ns/10ps
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // idle level of the active-low pins is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg     <= '1;
      pin_sync_out <= '1;
    end else begin
      meta_reg     <= pin_in;
      pin_sync_out <= meta_reg;
    end
  end
endmodule : pin_sync

// ---- logic/detach_timer.sv ----
// down counter in 10 ms ticks with a one-cycle expiry pulse
// assumes tick is a one-cycle pulse from the same clock
`timescale 1ns/10ps
module detach_timer
  import billboard_pkg::*;
#(
  parameter int unsigned WIDTH = TIMER_W
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             start,
  input  wire logic             stop,
  input  wire logic             tick,
  input  wire logic [WIDTH-1:0] load,
  output logic                  running,
  output logic                  expired,
  output logic      [WIDTH-1:0] count
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running <= 1'b0;
      expired <= 1'b0;
      count   <= '0;
    end else begin
      expired <= 1'b0;
      if (stop) begin
        running <= 1'b0;
      end else if (start) begin
        running <= 1'b1;
        count   <= load;
      end else if (running && tick) begin
        // a zero load expires on the first tick
        if (count <= WIDTH'(1)) begin
          count   <= '0;
          running <= 1'b0;
          expired <= 1'b1;
        end else begin
          count <= count - WIDTH'(1);
        end
      end
    end
  end

  property p_timer_load;
    @(posedge pclk) disable iff (!presetn)
    (start && !stop) |=> (running && count == $past(load));
  endproperty
  a_timer_load: assert property (p_timer_load) else $error("timer did not load");

  property p_timer_step;
    @(posedge pclk) disable iff (!presetn)
    (running && tick && !start && !stop && count > WIDTH'(1))
      |=> (count == $past(count) - WIDTH'(1)) && !expired;
  endproperty
  a_timer_step: assert property (p_timer_step) else $error("timer step wrong");

  property p_timer_expire;
    @(posedge pclk) disable iff (!presetn)
    (running && tick && !start && !stop && count <= WIDTH'(1))
      |=> expired ##1 !expired;
  endproperty
  a_timer_expire: assert property (p_timer_expire) else $error("expiry pulse wrong");
endmodule : detach_timer

// ---- test/far_side_model.sv ----
// far side: power delivery controller fail pins and usb host events
// assumes bench commands arrive as levels and one-cycle pulses
`timescale 1ns/10ps
module far_side_model (
  input  wire logic                                    pclk,
  input  wire logic                                    presetn,
  input  wire logic [4:0]                              fail_sel,
  input  wire logic                                    fail_on,
  input  wire logic                                    host_addr,
  input  wire logic                                    host_alt,
  output logic      [billboard_pkg::NUM_FAIL_PINS-1:0] gpio_in,
  output logic                                         addr_set,
  output logic                                         alt_string_req
);
  import billboard_pkg::*;

  // released pins sit at their pull-up level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_in <= '1;
    end else begin
      gpio_in <= '1;
      if (fail_on && fail_sel < 5'(NUM_FAIL_PINS)) begin
        gpio_in[fail_sel] <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_set       <= 1'b0;
      alt_string_req <= 1'b0;
    end else begin
      addr_set       <= host_addr;
      alt_string_req <= host_alt;
    end
  end
endmodule : far_side_model

// ---- test/tb_top.sv ----
// bench for the switchover block: apb master, scenario tasks, verdict
// assumes short tick and detach parameters so timers finish quickly
`timescale 1ns/10ps
module tb_top;
  import billboard_pkg::*;
  localparam int TK = 10;

  logic                     pclk = 1'b0;
  logic                     presetn;
  logic [APB_ADDR_W-1:0]    paddr;
  logic                     psel;
  logic                     penable;
  logic                     pwrite;
  logic [31:0]              pwdata;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  logic [NUM_FAIL_PINS-1:0] gpio_in;
  logic                     addr_set;
  logic                     alt_string_req;
  logic                     alt_string_grant;
  func_ctrl_type            func_ctrl;
  logic [1:0]               bm_configured;
  logic [4:0]               fail_sel;
  logic                     fail_on;
  logic                     host_addr;
  logic                     host_alt;
  int                       fails;
  int                       checked;

  always #2.5 pclk = ~pclk;

  billboard_switchover_control #(.TICK_CYCLES(TK), .DETACH_HOLD(4)) uut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gpio_in(gpio_in), .addr_set(addr_set),
    .alt_string_req(alt_string_req), .func_ctrl(func_ctrl),
    .alt_string_grant(alt_string_grant), .bm_configured(bm_configured));

  far_side_model far (
    .pclk(pclk), .presetn(presetn), .fail_sel(fail_sel), .fail_on(fail_on),
    .host_addr(host_addr), .host_alt(host_alt), .gpio_in(gpio_in),
    .addr_set(addr_set), .alt_string_req(alt_string_req));

  function automatic logic [19:0] ad(input logic [15:0] i);
    return {2'b00, i, 2'b00};
  endfunction : ad

  task automatic final_report;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // holds the request until pready is seen high at an edge
  task automatic apb(input logic w, input logic [19:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
      final_report();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [15:0] i, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, ad(i), d, r, e);
    chk({31'h0, e}, 32'h0000_0000);
  endtask : wr

  task automatic rd(input logic [15:0] i, input logic [7:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, ad(i), 8'h00, r, e);
    chk(r, {24'h00_0000, x});
  endtask : rd

  // bounded wait for the attach level
  task automatic wait_conn(input logic v);
    int n;
    n = 0;
    while (func_ctrl.connect !== v && n < 200) begin
      @(posedge pclk);
      n++;
    end
    if (func_ctrl.connect !== v) begin
      fails++;
      final_report();
    end
  endtask : wait_conn

  task automatic activate(input logic [4:0] s);
    wr(IDX_CONTROL, {2'b00, s, 1'b1});
    fail_sel <= s;
    fail_on  <= 1'b1;
    wait_conn(1'b0);
    chk(32'(func_ctrl.billboard_id), 32'h0000_0000);
    wait_conn(1'b1);
    chk(32'(func_ctrl.billboard_id), 32'h0000_0001);
    fail_on <= 1'b0;
    // released pin needs a far-side edge plus two sync flops to show in status
    repeat (4) @(posedge pclk);
  endtask : activate

  task automatic t_reset;
    logic [31:0] r;
    logic        e;
    rd(IDX_CONTROL, 8'h14);
    rd(IDX_TA_LO, 8'hd0);
    rd(IDX_TA_HI, 8'h07);
    rd(IDX_TB_LO, 8'hd0);
    rd(IDX_TB_HI, 8'h07);
    chk(32'(func_ctrl), 32'h0000_0002);
    chk(32'(bm_configured), 32'h0000_0000);
    apb(1'b0, 20'h0_0020, 8'h00, r, e);
    chk(32'(e), 32'h0000_0001);
    apb(1'b1, ad(IDX_STATUS), 8'hff, r, e);
    chk(32'(e), 32'h0000_0001);
    rd(IDX_STATUS, 8'h12);
    $display("test reset done");
  endtask : t_reset

  task automatic t_control;
    wr(IDX_CONTROL, 8'hff);
    rd(IDX_CONTROL, 8'h3f);
    wr(IDX_CONTROL, 8'h14);
    fail_sel <= 5'h0a;
    fail_on  <= 1'b1;
    repeat (30) @(posedge pclk);
    chk(32'(func_ctrl.connect), 32'h0000_0001);
    wr(IDX_CONTROL, {2'b00, SEL_RESERVED, 1'b1});
    fail_sel <= SEL_RESERVED;
    repeat (30) @(posedge pclk);
    chk(32'(func_ctrl.connect), 32'h0000_0001);
    fail_on <= 1'b0;
    repeat (5) @(posedge pclk);
    $display("test control done");
  endtask : t_control

  task automatic t_timer_a;
    time t0;
    wr(IDX_TA_LO, 8'h03);
    wr(IDX_TA_HI, 8'h00);
    activate(5'h0a);
    rd(IDX_STATUS, 8'h13);
    @(posedge pclk);
    host_addr <= 1'b1;
    @(posedge pclk);
    host_addr <= 1'b0;
    t0 = $time;
    rd(IDX_STATUS, 8'h17);
    wait_conn(1'b0);
    // three units of TK cycles, first unit may be short
    chk(32'(($time - t0) / 5 >= 20 && ($time - t0) / 5 <= 40), 32'h1);
    wait_conn(1'b1);
    chk(32'(func_ctrl.billboard_id), 32'h0000_0000);
    chk(32'(bm_configured), 32'h0000_0000);
    $display("test timer a done");
  endtask : t_timer_a

  task automatic t_timer_b;
    time  t0;
    logic seen;
    wr(IDX_TB_LO, 8'h02);
    wr(IDX_TB_HI, 8'h00);
    activate(5'h00);
    @(posedge pclk);
    host_alt <= 1'b1;
    @(posedge pclk);
    host_alt <= 1'b0;
    t0   = $time;
    seen = 1'b0;
    repeat (4) begin
      @(posedge pclk);
      if (alt_string_grant === 1'b1) seen = 1'b1;
    end
    chk(32'(seen), 32'h0000_0001);
    wait_conn(1'b0);
    chk(32'(($time - t0) / 5 >= 10 && ($time - t0) / 5 <= 30), 32'h1);
    wait_conn(1'b1);
    chk(32'(func_ctrl.billboard_id), 32'h0000_0000);
    $display("test timer b done");
  endtask : t_timer_b

  initial begin
    presetn   = 1'b0;
    paddr     = '0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    pwdata    = '0;
    fail_sel  = 5'h0a;
    fail_on   = 1'b0;
    host_addr = 1'b0;
    host_alt  = 1'b0;
    fails     = 0;
    checked   = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_control();
    t_timer_a();
    t_timer_b();
    final_report();
  end
endmodule : tb_top
